// ### hdl/fec_flash_erase_control.sv
// Flash erase and program control register with sequence checking, APB slave.
// Assumes a 25 MHz pclk, the block-protect byte and reset vector low byte
// supplied as steady inputs from the array, and the array acting on the outputs.
`timescale 1ns/10ps
`include "fec_params.svh"
module fec_flash_erase_control
  import fec_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int PAGE_BYTES = `FEC_PAGE_BYTES,
  parameter int ROW_BYTES = `FEC_ROW_BYTES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] block_protect_byte,
  input wire logic [7:0] reset_vector_low,
  output logic charge_pump_on,
  output logic array_high_voltage,
  output logic erase_run,
  output logic erase_whole,
  output logic [9:0] erase_page,
  output logic erase_trim,
  output logic [7:0] erase_fill,
  output logic prog_write,
  output logic [15:0] prog_addr,
  output logic [7:0] prog_data,
  output logic watchdog_clear
);

  // Geometry and address width the logic can serve
  if (ADDR_W < 18 || PAGE_BYTES != `FEC_PAGE_BYTES || ROW_BYTES != `FEC_ROW_BYTES)
  begin
    $error("fec_flash_erase_control: unsupported geometry or address width");
  end

  localparam logic [7:0] ROW_MAX = 8'(ROW_BYTES);

  // Control and sequence state
  logic pgm_r, erase_r, whole_r, high_voltage_enable_r, refused_r;
  fec_seq_e seq_r;
  logic [15:0] target_r;
  logic [7:0] row_cnt_r;

  // Bus decode
  logic [15:0] idx;
  logic setup_ok, done, wr_done, rd_done;
  logic hit_ctrl, hit_prot, hit_fwr, hit_stat, hit_wdog, mapped;

  assign idx = paddr[17:2];
  assign setup_ok = psel & penable & ~pready;
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite & ~pslverr;
  assign rd_done = done & ~pwrite & ~pslverr;
  assign hit_ctrl = (idx == `FEC_IDX_CTRL);
  assign hit_prot = (idx == `FEC_IDX_PROTECT);
  assign hit_fwr = (idx == `FEC_IDX_FLASH_WR);
  assign hit_stat = (idx == `FEC_IDX_STATUS);
  assign hit_wdog = (idx == `FEC_IDX_WDOG);
  assign mapped = hit_ctrl | hit_prot | hit_fwr | hit_stat | hit_wdog;

  // Protection decode
  logic [15:0] prot_start, wr_addr;
  logic unprotected, target_prot, hv_allowed;
  logic [7:0] wr_data;
  logic want_pgm, want_erase, sel_rise;

  assign prot_start = {2'b11, block_protect_byte, 6'h00};
  assign unprotected = (block_protect_byte == `FEC_UNPROTECTED);
  assign target_prot = ~unprotected & (target_r >= prot_start);
  // hv only with select and full sequence
  assign hv_allowed = (seq_r == FEC_LATCHED) & (pgm_r | erase_r)
    & ~(erase_r & whole_r & ~unprotected)
    & ~(~(erase_r & whole_r) & target_prot);

  assign wr_addr = pwdata[`FEC_WR_ADDR_LSB +: 16];
  assign wr_data = pwdata[`FEC_WR_DATA_LSB +: 8];
  assign want_pgm = pwdata[`FEC_BIT_PGM];
  assign want_erase = pwdata[`FEC_BIT_ERASE];
  assign sel_rise = (want_pgm & ~pgm_r) | (want_erase & ~erase_r);

  // APB handshake: one wait state per access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_ok;
      pslverr <= setup_ok & ~mapped;
    end
  end

  // Read data, loaded in the wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (setup_ok)
    begin
      prdata <= 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit_ctrl)
        begin
          prdata[3:0] <= {high_voltage_enable_r, whole_r, erase_r, pgm_r};
        end
        else if (hit_prot)
        begin
          prdata[7:0] <= block_protect_byte;
        end
        else if (hit_fwr)
        begin
          prdata[15:0] <= target_r;
        end
        else if (hit_stat)
        begin
          prdata[`FEC_ST_REFUSED] <= refused_r;
          prdata[`FEC_ST_STATE_LSB +: 2] <= seq_r;
          prdata[`FEC_ST_ROW_CNT_LSB +: 8] <= row_cnt_r;
          prdata[`FEC_ST_PAGE_LSB +: 10] <= target_r[15:6];
        end
        else if (hit_wdog)
        begin
          // read gives reset vector low byte
          prdata[7:0] <= reset_vector_low;
        end
      end
    end
  end

  // Operation selects
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pgm_r <= 1'b0;
      erase_r <= 1'b0;
      whole_r <= 1'b0;
    end
    else if (wr_done && hit_ctrl && pstrb[0])
    begin
      whole_r <= pwdata[`FEC_BIT_WHOLE];
      if (!(want_pgm && want_erase))
      begin
        pgm_r <= want_pgm;
        erase_r <= want_erase;
      end
    end
  end

  // High-voltage enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_voltage_enable_r <= 1'b0;
    end
    else if (wr_done && hit_ctrl && pstrb[0])
    begin
      if (!pwdata[`FEC_BIT_HIGH_VOLTAGE_ENABLE])
      begin
        high_voltage_enable_r <= 1'b0;
      end
      else if (hv_allowed)
      begin
        high_voltage_enable_r <= 1'b1;
      end
    end
  end

  // Refused high-voltage request flag, write one to clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refused_r <= 1'b0;
    end
    else if (wr_done && hit_ctrl && pstrb[0] && pwdata[`FEC_BIT_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable_r
             && !hv_allowed)
    begin
      refused_r <= 1'b1;
    end
    else if (wr_done && hit_stat && pstrb[0] && pwdata[`FEC_ST_REFUSED])
    begin
      refused_r <= 1'b0;
    end
  end

  // Sequence tracker
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_r <= FEC_IDLE;
    end
    else if (wr_done && hit_ctrl && pstrb[0] && !(want_pgm && want_erase))
    begin
      if (!want_pgm && !want_erase)
      begin
        seq_r <= FEC_IDLE;
      end
      else if (sel_rise)
      begin
        seq_r <= FEC_SELECTED;
      end
    end
    else if (rd_done && hit_prot && seq_r == FEC_SELECTED)
    begin
      seq_r <= FEC_PROT_READ;
    end
    else if (wr_done && hit_fwr && seq_r == FEC_PROT_READ)
    begin
      seq_r <= FEC_LATCHED;
    end
  end

  // Target address of the first flash write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target_r <= 16'h0000;
    end
    else if (wr_done && hit_fwr && seq_r == FEC_PROT_READ)
    begin
      target_r <= wr_addr;
    end
  end

  // Row programming: data writes under high voltage
  logic prog_ok;
  // at most one row per program cycle
  assign prog_ok = wr_done & hit_fwr & high_voltage_enable_r & pgm_r & (seq_r == FEC_LATCHED)
    & (wr_addr[15:5] == target_r[15:5]) & (row_cnt_r < ROW_MAX) & ~target_prot;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      row_cnt_r <= 8'h00;
    end
    else if (!pgm_r)
    begin
      row_cnt_r <= 8'h00;
    end
    else if (prog_ok)
    begin
      row_cnt_r <= row_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_write <= 1'b0;
      prog_addr <= 16'h0000;
      prog_data <= 8'h00;
    end
    else
    begin
      prog_write <= prog_ok;
      if (prog_ok)
      begin
        prog_addr <= wr_addr;
        prog_data <= wr_data;
      end
    end
  end

  // Watchdog service location; reads hold no state, writes pulse watchdog_clear, which reset clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_clear <= 1'b0;
    end
    else
    begin
      watchdog_clear <= wr_done & hit_wdog;
    end
  end

  // Array drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charge_pump_on <= 1'b0;
      array_high_voltage <= 1'b0;
      erase_run <= 1'b0;
      erase_whole <= 1'b0;
      erase_page <= 10'h000;
      erase_trim <= 1'b0;
      erase_fill <= `FEC_ERASED_BYTE;
    end
    else
    begin
      // pump and array voltage follow enable
      charge_pump_on <= high_voltage_enable_r;
      array_high_voltage <= high_voltage_enable_r;
      erase_run <= high_voltage_enable_r & erase_r;
      erase_whole <= high_voltage_enable_r & erase_r & whole_r & unprotected;
      erase_page <= target_r[15:6];
      erase_trim <= high_voltage_enable_r & erase_r
        & (whole_r | target_r[15:6] == `FEC_VECTOR_PAGE);
      erase_fill <= `FEC_ERASED_BYTE;
    end
  end

endmodule

// ### hdl/fec_params.svh
// Register indices, field positions and fixed values of the flash erase control.
// Included by the package and by the design; definitions only.
`ifndef FEC_PARAMS_SVH
`define FEC_PARAMS_SVH

// Register indices; byte address is four times the index
`define FEC_IDX_CTRL 16'h0001
`define FEC_IDX_PROTECT 16'h0002
`define FEC_IDX_FLASH_WR 16'h0003
`define FEC_IDX_STATUS 16'h0004
`define FEC_IDX_WDOG 16'hffff

// Control register fields
`define FEC_BIT_PGM 0
`define FEC_BIT_ERASE 1
`define FEC_BIT_WHOLE 2
`define FEC_BIT_HIGH_VOLTAGE_ENABLE 3
`define FEC_CTRL_RESET 4'h0

// Flash write register fields
`define FEC_WR_ADDR_LSB 0
`define FEC_WR_DATA_LSB 16

// Status register fields
`define FEC_ST_REFUSED 0
`define FEC_ST_STATE_LSB 1
`define FEC_ST_ROW_CNT_LSB 4
`define FEC_ST_PAGE_LSB 16

// Array geometry and bit sense
`define FEC_PAGE_BYTES 64
`define FEC_ROW_BYTES 32
`define FEC_ERASED_BYTE 8'hff
`define FEC_UNPROTECTED 8'hff
`define FEC_VECTOR_PAGE 10'h3ff

`endif

// ### hdl/fec_pkg.sv
// Types shared by the flash erase control design.
// Assumes fec_params.svh is on the include path.
package fec_pkg;
  `include "fec_params.svh"

  typedef enum logic [1:0] {
    FEC_IDLE = 2'b00,
    FEC_SELECTED = 2'b01,
    FEC_PROT_READ = 2'b10,
    FEC_LATCHED = 2'b11
  } fec_seq_e;
endpackage

// ### bench/fec_checker_sva.sv
// Port checker for the flash erase control.
// Bound into every design instance; sees its ports only.
`timescale 1ns/10ps
module fec_checker #(parameter int ADDR_W = 18) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [7:0] block_protect_byte,
  input wire logic [7:0] reset_vector_low,
  input wire logic charge_pump_on,
  input wire logic array_high_voltage,
  input wire logic erase_run,
  input wire logic erase_whole,
  input wire logic [9:0] erase_page,
  input wire logic erase_trim,
  input wire logic [7:0] erase_fill,
  input wire logic prog_write,
  input wire logic watchdog_clear
);
  wire done = psel && penable && pready;
  wire [15:0] idx = paddr[17:2];
  wire cwr = done && pwrite && idx == 16'h0001;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wd_wr;
    done && pwrite && idx == 16'hffff;
  endsequence
  sequence rd_of(logic [15:0] i);
    done && !pwrite && idx == i;
  endsequence
  pump_pair_a: assert property (charge_pump_on == array_high_voltage)
    else $error("pump and array differ");
  fill_ones_a: assert property (erase_fill == 8'hff)
    else $error("fill not ones");
  select_lock_a: assert property (rd_of(16'h0001) |-> !(prdata[0] && prdata[1]))
    else $error("both selects set");
  wd_read_a: assert property (rd_of(16'hffff) |-> prdata == {24'h0, reset_vector_low})
    else $error("watchdog read wrong");
  wd_clear_a: assert property (wd_wr |-> ##[1:2] watchdog_clear)
    else $error("no watchdog clear");
  whole_guard_a: assert property (erase_whole |-> $past(block_protect_byte) == 8'hff)
    else $error("whole erase while protected");
  trim_vector_a: assert property (erase_run && erase_page == 10'h3ff |-> erase_trim)
    else $error("trim kept");
  page_hold_a: assert property (erase_run && $past(erase_run) |-> $stable(erase_page))
    else $error("page moved");
  high_voltage_enable_cause_a: assert property ($rose(charge_pump_on) |->
    $past(cwr) || $past(cwr, 2) || $past(cwr, 3)) else $error("pump without write");
  reset_clear_a: assert property ($rose(presetn) |-> !charge_pump_on && !erase_run)
    else $error("pump on after reset");
  prog_hv_a: assert property (prog_write |-> charge_pump_on && array_high_voltage)
    else $error("program write without high voltage");
endmodule

bind fec_flash_erase_control fec_checker #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### bench/flash_erase_control_tb.sv
// Bench for the flash erase control over APB.
// Array inputs are steady levels set by the bench.
`timescale 1ns/10ps
module flash_erase_control_tb;
  localparam logic [17:0] CTRL = 18'h4, PROT = 18'h8, FWR = 18'hc, STAT = 18'h10;
  localparam logic [17:0] WDOG = 18'h3fffc, UNM = 18'h14;
  localparam logic [3:0] SEL [6] = '{4'h2, 4'h2, 4'h2, 4'h6, 4'h6, 4'h1};
  localparam logic [7:0] BPB [6] = '{8'hff, 8'hfe, 8'hfe, 8'hfe, 8'hff, 8'hff};
  localparam logic [15:0] TGT [6] = '{16'hffc5, 16'hff85, 16'h1000, 16'h1000,
    16'h1000, 16'h2000};
  localparam logic OK [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] block_protect_byte = 8'hff, reset_vector_low = 8'h5a, erase_fill, prog_data;
  logic pready, pslverr, charge_pump_on, array_high_voltage, erase_run, erase_whole;
  logic erase_trim, prog_write, watchdog_clear;
  logic [9:0] erase_page;
  logic [15:0] prog_addr;
  int err_total = 0, comparisons = 0;

  fec_flash_erase_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .block_protect_byte(block_protect_byte), .reset_vector_low(reset_vector_low),
    .charge_pump_on(charge_pump_on), .array_high_voltage(array_high_voltage),
    .erase_run(erase_run), .erase_whole(erase_whole), .erase_page(erase_page),
    .erase_trim(erase_trim), .erase_fill(erase_fill), .prog_write(prog_write),
    .prog_addr(prog_addr), .prog_data(prog_data), .watchdog_clear(watchdog_clear));

  initial
  forever #20 pclk = ~pclk;

  task automatic complete_run;
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, then releases
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 16)
    begin
      err_total++;
      complete_run;
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [17:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd, e);
  endtask

  function automatic logic [31:0] outs();
    return {erase_fill, 4'h0, erase_page, 5'h0, charge_pump_on, array_high_voltage,
      erase_run, erase_whole, erase_trim};
  endfunction

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CTRL, 32'h0);
    rdc(WDOG, 32'h5a);
    wr(WDOG, 32'h0);
    apb(1'b0, UNM, '0);
    chk({31'h0, er}, 32'h1);
    wr(CTRL, 32'h3);
    rdc(CTRL, 32'h0);
    wr(CTRL, 32'h2);
    wr(CTRL, 32'h3);
    rdc(CTRL, 32'h2);
    // Skipped protect read refuses high voltage
    wr(FWR, 32'h1000);
    wr(CTRL, 32'ha);
    rdc(CTRL, 32'h2);
    rdc(STAT, 32'h3);
    wr(STAT, 32'h1);
    wr(CTRL, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      logic t;
      t = OK[i] & SEL[i][1] & (SEL[i][2] | (&TGT[i][15:6]));
      block_protect_byte <= BPB[i];
      wr(CTRL, {28'h0, SEL[i]});
      rdc(PROT, {24'h0, BPB[i]});
      wr(FWR, {16'h0, TGT[i]});
      rdc(STAT, {6'h0, TGT[i][15:6], 16'h6});
      wr(CTRL, {28'h0, SEL[i] | 4'h8});
      rdc(CTRL, {28'h0, SEL[i] | {OK[i], 3'h0}});
      chk(outs(), {8'hff, 4'h0, TGT[i][15:6], 5'h0, OK[i], OK[i], OK[i] & SEL[i][1],
        OK[i] & SEL[i][2], t});
      if (SEL[i][0])
      begin
        wr(FWR, 32'h003c_2003);
        wr(FWR, 32'h0055_2040);
        chk({prog_addr, 8'h0, prog_data}, 32'h2003_003c);
        rdc(STAT, {6'h0, TGT[i][15:6], 16'h16});
      end
      wr(STAT, 32'h1);
      if (i == 0)
      begin
        // Reset in mid erase
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(outs(), 32'hff00_0000);
        rdc(CTRL, 32'h0);
        rdc(WDOG, 32'h5a);
      end
      else
      begin
        wr(CTRL, {28'h0, OK[i], 3'h0});
        rdc(CTRL, {28'h0, OK[i], 3'h0});
        chk(outs(), {8'hff, 4'h0, TGT[i][15:6], 5'h0, OK[i], OK[i], 3'h0});
        wr(CTRL, 32'h0);
      end
    end
    complete_run;
  end
endmodule
